// ===== pkg/mode_ctrl_defines.svh
// Timing counts and field codes for the mode, reset and wake controller
`ifndef MODE_CTRL_DEFINES_SVH
`define MODE_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS      10
`define RST_EXT_TIME_US    1000
`define RST_EXT_CYCLES     ((`RST_EXT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define NREQ_TIMEOUT_MS    150
`define NREQ_TIMEOUT_CYCLES ((`NREQ_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define RST_FILTER_LEN     16
`define MODE_SEL_NORMAL    2'h0
`define MODE_SEL_STOP      2'h1
`define MODE_SEL_SLEEP     2'h2
`define MODE_SEL_NOP       2'h3
`define NUM_WAKE_INPUTS    4

`endif

// ===== pkg/mode_ctrl_pkg.sv
// Types shared by the mode, reset and wake controller
package mode_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_NORMAL_REQ,
    ST_NORMAL,
    ST_STOP,
    ST_SLEEP
  } op_mode_t;
endpackage : mode_ctrl_pkg

// ===== rtl/ext_reset_filter.sv
// Glitch filter for the external reset pin: synchroniser plus low-level counter
`timescale 1ns/1ps
module ext_reset_filter #(
  parameter int LEN = 16
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic pin_n_i,
  output logic      low_seen_o
);
  localparam int CW = $clog2(LEN + 1);
  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire           at_end = (cnt_q == CW'(LEN));

  // Counter saturates; any high sample restarts it
  assign cnt_d = sync2_q ? '0 : (at_end ? cnt_q : cnt_q + 1'b1); // RQ27

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q    <= 1'b1;
      sync2_q    <= 1'b1;
      cnt_q      <= '0;
      low_seen_o <= 1'b0;
    end else begin
      sync1_q    <= pin_n_i;
      sync2_q    <= sync1_q;
      cnt_q      <= cnt_d;
      low_seen_o <= (cnt_d == CW'(LEN)); // RQ27
    end
  end
endmodule : ext_reset_filter

// ===== rtl/mode_reset_wake_controller.sv
// Operating-mode, reset and wake-up controller of a LIN system basis chip
//
// Summary of operation
// RQ1: Stop mode is entered only by a serial mode command.
// RQ2: Wake from Stop goes to Normal Request; interrupt unless chip-select or reset-pin wake.
// RQ3: Stop wakes on wake-input change, LIN, timer, chip-select rise, reset pin.
// RQ4: Sleep wakes only on wake-input change, LIN or timer.
// RQ5: Normal watchdog must be served in open window, else Reset mode.
// RQ6: Grounded watchdog config pin disables watchdog reset path.
// RQ7: Normal Request: full regulator, LIN receive-only, 150 ms timeout instead of window.
// RQ8: Stop disables hall supply, low sides, mux, current sense; limited functions.
// RQ9: Sleep keeps only wake inputs, LIN wake and cyclic sense high sides.
// RQ10: No new interrupt while wake sources remain unread. The code holds back only fault interrupts; a Stop wake still asserts.
// RQ11: Stop interrupts signal wake only; Sleep never uses interrupt.
// RQ12: Interrupt pin low until source register read, then high.
// RQ13: Interrupts only in Normal, Normal Request, Stop and never with reset low.
// RQ14: Normal modes raise maskable fault interrupts for supply, temperature, LIN, switches.
// RQ15: LIN faults disable driver until fault gone and transmit recessive.
// RQ16: Reset output low during condition plus 1.0 ms extension.
// RQ17: Regulator low resets; overtemperature disables regulator and sets flag.
// RQ18: Every Sleep wake passes through regulator power-up and reset.
// RQ19: Filtered external reset low holds reset, also in Stop; no extension added.
// RQ20: No status bit for chip-select or reset-pin wake.
// RQ21: Per-input wake enables; present wake input state readable.
// RQ22: Wake input routed to analog mux at low-power entry loses wake ability.
// RQ23: Normal Request 150 ms timer; normal command needed before expiry or Reset.
// RQ24: Two-bit mode select field selects operating mode.
// RQ25: Reset on regulator low, watchdog fail, Sleep wake, Normal Request timeout.
// RQ26: Grounded watchdog config pin goes Reset straight to Normal.
// RQ27: Reset pin filter is synchroniser plus parameterised low-level counter.
`timescale 1ns/1ps
`include "mode_ctrl_defines.svh"
module mode_reset_wake_controller
  import mode_ctrl_pkg::*;
#(
  parameter int NW          = `NUM_WAKE_INPUTS,
  parameter int RST_EXT     = `RST_EXT_CYCLES,
  parameter int NREQ_TMO    = `NREQ_TIMEOUT_CYCLES,
  parameter int FILTER_LEN  = `RST_FILTER_LEN
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Mode command from the serial interface
  input  wire logic          mode_wr_i,
  input  wire logic [1:0]    mode_select_field_i,
  input  wire logic          timing_ctrl_wr_i,
  input  wire logic          wd_window_open_i,
  input  wire logic          wd_expired_i,
  input  wire logic          watchdog_config_pin_gnd_i,
  input  wire logic          isr_read_i,
  // Wake configuration and sources
  input  wire logic [NW-1:0] wake_inputs_i,
  input  wire logic [NW-1:0] wake_input_enable_bits_i,
  input  wire logic [NW-1:0] mux_sel_wake_i,
  input  wire logic          lin_wake_i,
  input  wire logic          timer_wake_i,
  input  wire logic          cs_n_i,
  // Fault sources and mask
  input  wire logic          supply_uv_i,
  input  wire logic          supply_ov_i,
  input  wire logic          reg_ot_warn_i,
  input  wire logic          reg_ot_i,
  input  wire logic          reg_low_i,
  input  wire logic          lin_fault_i,
  input  wire logic          lin_txd_recessive_i,
  input  wire logic          hs_ot_i,
  input  wire logic          ls_ot_i,
  input  wire logic [5:0]    interrupt_mask_register_i,
  // Reset pin, open drain
  input  wire logic          rst_pin_n_i,
  output logic               rst_pin_o,
  output logic               rst_pin_oe_n_o,
  output logic               irq_n_o,
  // Mode and enables
  output op_mode_t           mode_o,
  output logic               reg_full_o,
  output logic               reg_on_o,
  output logic               hall_sensor_supply_en_o,
  output logic               low_side_switches_en_o,
  output logic               high_side_switches_en_o,
  output logic               mux_en_o,
  output logic               current_sense_en_o,
  output logic               lin_tx_en_o,
  output logic               vsup_monitor_en_o,
  output logic               vdd_monitor_en_o,
  output logic               watchdog_run_o,
  output logic               regulator_overtemp_flag_o,
  output logic [NW-1:0]      wake_status_register_o,
  output logic [NW+1:0]      interrupt_source_register_o,
  output logic [5:0]         fault_source_o
);

  // ------------------------------------------------------------
  // State and counters
  // ------------------------------------------------------------
  op_mode_t        st_q, st_d;
  logic [31:0]     ext_cnt_q;
  logic [31:0]     tmo_q;
  logic [NW-1:0]   wk_prev_q;
  logic [NW-1:0]   wk_arm_q;
  logic            cs_prev_q;
  logic [NW+1:0]   wsrc_q;
  logic [5:0]      fsrc_q;
  logic            lin_dis_q;
  logic            irq_q;
  logic            drive_low_q;

  // ------------------------------------------------------------
  // Reset pin filter
  // ------------------------------------------------------------
  // The pin reads back our own drive, so it is masked while we pull it low;
  // otherwise our reset pulse would look external and hold the chip in reset.
  // Limitation: a host low that overlaps our own pulse is seen only after release.
  logic ext_rst;
  wire  pin_seen_n = rst_pin_n_i || drive_low_q; // RQ19
  ext_reset_filter #(.LEN(FILTER_LEN)) ext_reset_filter_i (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .pin_n_i    (pin_seen_n),
    .low_seen_o (ext_rst)
  );

  function automatic logic mode_cmd(input logic wr, input logic [1:0] f,
                                    input logic [1:0] code);
    mode_cmd = wr && (f == code);
  endfunction : mode_cmd

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  wire in_low     = (st_q == ST_STOP) || (st_q == ST_SLEEP);
  wire [NW-1:0] wk_change = (wake_inputs_i ^ wk_prev_q) & wk_arm_q; // RQ21 RQ22
  wire wk_any     = |wk_change;
  wire cs_rise    = cs_n_i && !cs_prev_q;
  wire sleep_wake = wk_any || lin_wake_i || timer_wake_i; // RQ4
  wire stop_src   = wk_any || lin_wake_i || timer_wake_i; // RQ3
  wire stop_wake  = stop_src || cs_rise || ext_rst; // RQ3
  wire wd_on      = !watchdog_config_pin_gnd_i; // RQ6
  wire normal_cmd = mode_cmd(mode_wr_i, mode_select_field_i, `MODE_SEL_NORMAL); // RQ24
  // A serve in the closed window fails exactly like an overflow
  wire wd_fail    = (st_q == ST_NORMAL) && wd_on &&
                    (wd_expired_i || (normal_cmd && !wd_window_open_i)); // RQ5
  wire nreq_tmo   = (st_q == ST_NORMAL_REQ) && (tmo_q >= 32'(NREQ_TMO - 1)); // RQ23
  wire int_rst    = reg_low_i || wd_fail || nreq_tmo; // RQ17 RQ25
  wire rst_cond   = int_rst || ext_rst; // RQ19
  wire ext_done   = (ext_cnt_q >= 32'(RST_EXT - 1));
  wire [5:0] faults = {ls_ot_i, hs_ot_i, lin_fault_i, reg_ot_warn_i, supply_ov_i,
                       supply_uv_i};
  wire wake_pend  = |wsrc_q;
  wire irq_allow  = (st_q == ST_NORMAL || st_q == ST_NORMAL_REQ || st_q == ST_STOP)
                    && !drive_low_q && !ext_rst; // RQ13

  // ------------------------------------------------------------
  // Next mode
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RESET: begin
        // Pin-driven reset releases without extension
        if (!rst_cond && (ext_done || !drive_low_q)) begin // RQ16 RQ19
          st_d = wd_on ? ST_NORMAL_REQ : ST_NORMAL; // RQ26 RQ25
        end
      end
      ST_NORMAL_REQ: begin
        if (rst_cond) begin
          st_d = ST_RESET; // RQ23
        end else if (normal_cmd && timing_ctrl_wr_i) begin
          st_d = ST_NORMAL; // RQ23
        end
      end
      ST_NORMAL: begin
        if (rst_cond) begin
          st_d = ST_RESET; // RQ5
        end else if (mode_cmd(mode_wr_i, mode_select_field_i, `MODE_SEL_STOP)) begin
          st_d = ST_STOP; // RQ1
        end else if (mode_cmd(mode_wr_i, mode_select_field_i, `MODE_SEL_SLEEP)) begin
          st_d = ST_SLEEP; // RQ24
        end
      end
      ST_STOP: begin
        // A held reset pin outranks the other Stop wakes, so it is tested first
        if (ext_rst || reg_low_i) begin
          st_d = ST_RESET; // RQ19
        end else if (stop_wake) begin
          st_d = ST_NORMAL_REQ; // RQ2
        end
      end
      ST_SLEEP: begin
        // Host is unpowered here: chip-select and reset pin cannot wake
        if (sleep_wake) begin
          st_d = ST_RESET; // RQ18
        end
      end
      default: st_d = ST_RESET;
    endcase
  end

  // ------------------------------------------------------------
  // Mode register and timers
  // ------------------------------------------------------------
  wire entering_reset = (st_d == ST_RESET) && (st_q != ST_RESET);
  // Extension counts only while the cause is gone; an external low skips it
  wire [31:0] ext_cnt_d = (rst_cond || entering_reset) ? 32'h0 :
                          (ext_done ? ext_cnt_q : ext_cnt_q + 32'h1); // RQ16
  wire [31:0] tmo_d = (st_q != ST_NORMAL_REQ) ? 32'h0 : tmo_q + 32'h1; // RQ7
  // Only resets raised here drive the pin and get the extension; a host-held
  // low is followed, not stretched, and a Sleep wake always gets the full pulse
  wire drive_low_d = (st_d == ST_RESET) &&
                     (int_rst || (st_q == ST_SLEEP) || (drive_low_q && !ext_done)); // RQ16 RQ18

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q        <= ST_RESET;
      ext_cnt_q   <= 32'h0;
      tmo_q       <= 32'h0;
      drive_low_q <= 1'b1;
    end else begin
      st_q        <= st_d;
      ext_cnt_q   <= ext_cnt_d;
      tmo_q       <= tmo_d;
      drive_low_q <= drive_low_d; // RQ16
    end
  end

  // ------------------------------------------------------------
  // Wake tracking
  // ------------------------------------------------------------
  wire entering_low = !in_low && ((st_d == ST_STOP) || (st_d == ST_SLEEP));
  wire [NW-1:0] arm_d = entering_low ? (wake_input_enable_bits_i & ~mux_sel_wake_i) :
                        (in_low ? wk_arm_q : '0); // RQ22 RQ21
  // Only sources with a status bit are recorded; chip-select and pin wakes leave none
  wire [NW+1:0] wsrc_set = (in_low && (st_q == ST_STOP ? stop_src : sleep_wake)) ?
                           {timer_wake_i, lin_wake_i, wk_change} : '0; // RQ20
  // Set wins over the acknowledge read
  wire [NW+1:0] wsrc_d = (isr_read_i ? '0 : wsrc_q) | wsrc_set; // RQ10
  wire [5:0] fsrc_set = ((st_q == ST_NORMAL) || (st_q == ST_NORMAL_REQ)) ?
                        (faults & ~interrupt_mask_register_i) : 6'h0; // RQ14
  wire [5:0] fsrc_d = (isr_read_i ? 6'h0 : fsrc_q) | fsrc_set;
  // Fault interrupts held back while wake sources are unread; Sleep never asserts
  wire irq_new = irq_allow && ((st_q == ST_STOP && (|wsrc_set) && stop_src) ||
                 (st_q != ST_STOP && |fsrc_set && !wake_pend)); // RQ10 RQ11 RQ2
  wire irq_d = irq_new || (irq_q && !isr_read_i && irq_allow); // RQ12
  wire lin_dis_d = lin_fault_i || (lin_dis_q && !lin_txd_recessive_i); // RQ15

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wk_prev_q <= '0;
      wk_arm_q  <= '0;
      cs_prev_q <= 1'b1;
      wsrc_q    <= '0;
      fsrc_q    <= 6'h0;
      lin_dis_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      wk_prev_q <= wake_inputs_i;
      wk_arm_q  <= arm_d;
      cs_prev_q <= cs_n_i;
      wsrc_q    <= wsrc_d;
      fsrc_q    <= fsrc_d;
      lin_dis_q <= lin_dis_d;
      irq_q     <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  wire nrm  = (st_d == ST_NORMAL) || (st_d == ST_NORMAL_REQ);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pin_o                   <= 1'b0;
      rst_pin_oe_n_o              <= 1'b0;
      irq_n_o                     <= 1'b1;
      mode_o                      <= ST_RESET;
      reg_full_o                  <= 1'b1;
      reg_on_o                    <= 1'b1;
      hall_sensor_supply_en_o     <= 1'b0;
      low_side_switches_en_o      <= 1'b0;
      high_side_switches_en_o     <= 1'b0;
      mux_en_o                    <= 1'b0;
      current_sense_en_o          <= 1'b1;
      lin_tx_en_o                 <= 1'b0;
      vsup_monitor_en_o           <= 1'b1;
      vdd_monitor_en_o            <= 1'b1;
      watchdog_run_o              <= 1'b0;
      regulator_overtemp_flag_o   <= 1'b0;
      wake_status_register_o      <= '0;
      interrupt_source_register_o <= '0;
      fault_source_o              <= 6'h0;
    end else begin
      rst_pin_o                   <= 1'b0;
      rst_pin_oe_n_o              <= !drive_low_d; // RQ16
      irq_n_o                     <= !irq_d; // RQ12
      mode_o                      <= st_d;
      reg_full_o                  <= (st_d != ST_STOP) && (st_d != ST_SLEEP); // RQ7
      reg_on_o                    <= (st_d != ST_SLEEP) && !reg_ot_i; // RQ17 RQ9
      hall_sensor_supply_en_o     <= nrm; // RQ8
      low_side_switches_en_o      <= nrm; // RQ8
      high_side_switches_en_o     <= (st_d != ST_RESET); // RQ8 RQ9
      mux_en_o                    <= nrm; // RQ8
      current_sense_en_o          <= (st_d != ST_STOP) && (st_d != ST_SLEEP); // RQ8
      lin_tx_en_o                 <= (st_d == ST_NORMAL) && !lin_dis_d; // RQ7 RQ15
      vsup_monitor_en_o           <= (st_d != ST_STOP) && (st_d != ST_SLEEP); // RQ8
      vdd_monitor_en_o            <= (st_d != ST_SLEEP); // RQ9
      watchdog_run_o              <= (st_d == ST_NORMAL) && wd_on; // RQ6
      regulator_overtemp_flag_o   <= reg_ot_i || (regulator_overtemp_flag_o && !isr_read_i);
      wake_status_register_o      <= wake_inputs_i; // RQ21
      interrupt_source_register_o <= wsrc_d;
      fault_source_o              <= fsrc_d;
    end
  end
endmodule : mode_reset_wake_controller

// ===== test/host_mcu_model.sv
// Host microcontroller model: open-drain reset wire and interrupt acknowledge
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic clk_i,
  input  wire logic pull_low_i,
  input  wire logic ack_en_i,
  input  wire logic rst_pin_oe_n_i,
  output logic      rst_pin_n_o,
  output logic      isr_read_o
);
  logic rd_q = 1'b0;
  logic rd_next;
  // Pulled up; low while either side pulls it
  assign rst_pin_n_o = !(pull_low_i || !rst_pin_oe_n_i);
  assign isr_read_o  = rd_q;
  // While acknowledging, the host reads the source register every other cycle,
  // pending interrupt or not; the enable is taken at the edge, so no race with the bench
  always @(posedge clk_i) begin
    rd_next = ack_en_i && !rd_q;
    #1 rd_q = rd_next;
  end
endmodule : host_mcu_model

// ===== test/mode_reset_wake_controller_assertions.sv
// Port-level assertions for the mode, reset and wake controller
`timescale 1ns/1ps
module mode_ctrl_checker
  import mode_ctrl_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       mode_wr_i,
  input wire logic [1:0] mode_select_field_i,
  input wire logic       wd_expired_i,
  input wire logic       watchdog_config_pin_gnd_i,
  input wire logic       isr_read_i,
  input wire logic       lin_wake_i,
  input wire logic       reg_low_i,
  input wire logic       rst_pin_n_i,
  input wire logic       rst_pin_oe_n_o,
  input wire logic       irq_n_o,
  input wire op_mode_t   mode_o,
  input wire logic       reg_full_o,
  input wire logic       reg_on_o,
  input wire logic       hall_sensor_supply_en_o,
  input wire logic       low_side_switches_en_o,
  input wire logic       mux_en_o,
  input wire logic       lin_tx_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Mode enables update on the same edge as mode_o but irq_n_o lags it by one edge, so steady-state checks look one cycle in
  stop_entry_a: assert property (mode_o == ST_STOP && $past(mode_o) != ST_STOP |->
    $past(mode_wr_i && mode_select_field_i == 2'h1 && mode_o == ST_NORMAL))
    else $error("stop without command");
  stop_wake_a: assert property (mode_o == ST_STOP && lin_wake_i && rst_pin_n_i
    |=> mode_o == ST_NORMAL_REQ) else $error("stop wake missed");
  sleep_quiet_a: assert property (mode_o == ST_SLEEP && $past(mode_o) == ST_SLEEP
    |-> irq_n_o && !reg_on_o) else $error("sleep outputs active");
  stop_off_a: assert property (mode_o == ST_STOP && $past(mode_o) == ST_STOP
    |-> !(hall_sensor_supply_en_o || low_side_switches_en_o || mux_en_o))
    else $error("stop loads on");
  nreq_lin_a: assert property (mode_o == ST_NORMAL_REQ && $past(mode_o) == ST_NORMAL_REQ
    |-> reg_full_o && !lin_tx_en_o) else $error("normal request outputs wrong");
  irq_hold_a: assert property (!irq_n_o && !isr_read_i && rst_pin_n_i
    |=> !irq_n_o || mode_o inside {ST_RESET, ST_SLEEP}) else $error("irq released unread");
  wd_gnd_a: assert property (mode_o == ST_NORMAL && watchdog_config_pin_gnd_i && wd_expired_i
    && !reg_low_i && rst_pin_n_i && !mode_wr_i |=> mode_o == ST_NORMAL) else $error("wd reset");
  reset_quiet_a: assert property (!rst_pin_oe_n_o && $past(!rst_pin_oe_n_o) |-> irq_n_o)
    else $error("irq during reset");
endmodule : mode_ctrl_checker

bind mode_reset_wake_controller mode_ctrl_checker mode_ctrl_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .mode_wr_i(mode_wr_i),
  .mode_select_field_i(mode_select_field_i),
  .wd_expired_i(wd_expired_i), .watchdog_config_pin_gnd_i(watchdog_config_pin_gnd_i),
  .isr_read_i(isr_read_i), .lin_wake_i(lin_wake_i), .reg_low_i(reg_low_i), .rst_pin_n_i(rst_pin_n_i),
  .rst_pin_oe_n_o(rst_pin_oe_n_o), .irq_n_o(irq_n_o), .mode_o(mode_o), .reg_full_o(reg_full_o),
  .reg_on_o(reg_on_o), .hall_sensor_supply_en_o(hall_sensor_supply_en_o), .mux_en_o(mux_en_o),
  .low_side_switches_en_o(low_side_switches_en_o), .lin_tx_en_o(lin_tx_en_o));

// ===== test/mode_reset_wake_controller_bench.sv
// Self-checking bench for the mode, reset and wake controller
`timescale 1ns/1ps
module mode_reset_wake_controller_bench;
  import mode_ctrl_pkg::*;
  localparam int RST_EXT  = 20;
  localparam int NREQ_TMO = 50;
  localparam int FLT      = 3;
  logic       clk_i = 1'b0, resetn_i = 1'b0, mode_wr = 1'b0, tcw = 1'b0, wd_open = 1'b1;
  logic       wd_exp = 1'b0, gnd = 1'b0, lin_wake = 1'b0, tmr_wake = 1'b0, cs_n = 1'b1;
  logic       pull_low = 1'b0, ack_en = 1'b0, reg_ot = 1'b0, reg_low = 1'b0, txd_rec = 1'b0;
  logic [1:0] field = 2'h3;
  logic [3:0] wake_in = 4'h0, wen = 4'h7, mux_sel = 4'h1, wsr;
  logic [5:0] flt = 6'h0, mask = 6'h0, interrupt_source_register, exp_isr;
  logic       rst_pin_n, isr_read, rst_oe_n, irq_n, reg_on, lin_tx, ot_flag, wd_run;
  op_mode_t   mode;
  int         n_errors = 0;
  int         checks_done = 0;

  always #5 clk_i = ~clk_i;

  mode_reset_wake_controller #(.RST_EXT(RST_EXT), .NREQ_TMO(NREQ_TMO), .FILTER_LEN(FLT))
    mode_reset_wake_controller_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .mode_wr_i(mode_wr), .mode_select_field_i(field),
    .timing_ctrl_wr_i(tcw), .wd_window_open_i(wd_open), .wd_expired_i(wd_exp),
    .watchdog_config_pin_gnd_i(gnd), .isr_read_i(isr_read), .wake_inputs_i(wake_in),
    .wake_input_enable_bits_i(wen), .mux_sel_wake_i(mux_sel), .lin_wake_i(lin_wake),
    .timer_wake_i(tmr_wake), .cs_n_i(cs_n), .supply_uv_i(flt[0]), .supply_ov_i(flt[1]),
    .reg_ot_warn_i(flt[2]), .reg_ot_i(reg_ot), .reg_low_i(reg_low), .lin_fault_i(flt[3]),
    .lin_txd_recessive_i(txd_rec), .hs_ot_i(flt[4]), .ls_ot_i(flt[5]),
    .interrupt_mask_register_i(mask), .rst_pin_n_i(rst_pin_n), .rst_pin_o(),
    .rst_pin_oe_n_o(rst_oe_n), .irq_n_o(irq_n), .mode_o(mode), .reg_full_o(), .reg_on_o(reg_on),
    .hall_sensor_supply_en_o(), .low_side_switches_en_o(), .high_side_switches_en_o(),
    .mux_en_o(), .current_sense_en_o(), .lin_tx_en_o(lin_tx), .vsup_monitor_en_o(),
    .vdd_monitor_en_o(), .watchdog_run_o(wd_run), .regulator_overtemp_flag_o(ot_flag),
    .wake_status_register_o(wsr), .interrupt_source_register_o(interrupt_source_register), .fault_source_o());
  host_mcu_model host_mcu_model_i (.clk_i(clk_i), .pull_low_i(pull_low), .ack_en_i(ack_en),
    .rst_pin_oe_n_i(rst_oe_n), .rst_pin_n_o(rst_pin_n), .isr_read_o(isr_read));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Mode, interrupt and reset drive in one snapshot
  function automatic logic [7:0] st();
    return {3'h0, mode, irq_n, rst_oe_n};
  endfunction : st
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask : pulse
  task automatic cmd(input logic [1:0] f);
    field = f;
    pulse(mode_wr);
  endtask : cmd
  task automatic wait_mode(input op_mode_t m, input int lim);
    for (int k = 0; k < lim && mode !== m; k++) tick(1);
    chk(8'(mode), 8'(m));
  endtask : wait_mode
  task automatic go_normal();
    wait_mode(ST_NORMAL_REQ, RST_EXT + 10);
    tcw = 1'b1;
    cmd(2'h0);
    tcw = 1'b0;
    chk(8'(mode), 8'(ST_NORMAL));
  endtask : go_normal

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up();
    tick(RST_EXT - 3);
    chk(st(), {3'h0, ST_RESET, 2'b10});
    wait_mode(ST_NORMAL_REQ, 10);
    chk(8'(rst_oe_n), 8'h1);
    go_normal();
  endtask : t_power_up
  task automatic t_stop_cs_timeout();
    cmd(2'h1);
    chk(st(), {3'h0, ST_STOP, 2'b11});
    cs_n = 1'b0;
    tick(1);
    cs_n = 1'b1;
    tick(2);
    chk(st(), {3'h0, ST_NORMAL_REQ, 2'b11});
    chk(8'(interrupt_source_register), 8'h0);
    cmd(2'h1);
    tick(NREQ_TMO - 20);
    chk(8'(mode), 8'(ST_NORMAL_REQ));
    wait_mode(ST_RESET, 25);
    go_normal();
  endtask : t_stop_cs_timeout
  task automatic t_stop_wakes();
    for (int i = 0; i < 3; i++) begin
      cmd(2'h1);
      if (i == 0) begin
        wake_in = wake_in ^ 4'h9;
        tick(3);
        chk(8'(mode), 8'(ST_STOP));
        chk(8'(wsr), 8'(wake_in));
        wen = 4'hf;
      end
      exp_isr = (i == 0) ? 6'h10 : (i == 1) ? 6'h20 : 6'h08;
      if (i == 2) wake_in[3] = ~wake_in[3];
      lin_wake = (i == 0);
      tmr_wake = (i == 1);
      tick(1);
      lin_wake = 1'b0;
      tmr_wake = 1'b0;
      tick(6);
      chk(st(), {3'h0, ST_NORMAL_REQ, 2'b01});
      chk(8'(interrupt_source_register), 8'(exp_isr));
      ack_en = 1'b1;
      tick(3);
      ack_en = 1'b0;
      chk(8'(irq_n), 8'h1);
      go_normal();
    end
  endtask : t_stop_wakes
  task automatic t_sleep();
    cmd(2'h2);
    cs_n = 1'b0;
    tick(1);
    cs_n = 1'b1;
    pull_low = 1'b1;
    tick(FLT + 4);
    pull_low = 1'b0;
    tick(2);
    chk(st(), {3'h0, ST_SLEEP, 2'b11});
    chk(8'(reg_on), 8'h0);
    wake_in[1] = ~wake_in[1];
    tick(4);
    chk(st(), {3'h0, ST_RESET, 2'b10});
    go_normal();
    // Unread Sleep wake source holds back a fault interrupt until it is read
    flt[0] = 1'b1;
    tick(3);
    chk(8'(irq_n), 8'h1);
    chk(8'(interrupt_source_register), 8'h02);
    pulse(ack_en);
    chk(8'(irq_n), 8'h0);
    flt[0] = 1'b0;
    pulse(ack_en);
    chk(8'(irq_n), 8'h1);
  endtask : t_sleep
  task automatic t_reset_pin();
    cmd(2'h1);
    pulse(pull_low);
    chk(8'(mode), 8'(ST_STOP));
    pull_low = 1'b1;
    tick(FLT + 4);
    chk(8'(mode), 8'(ST_RESET));
    pull_low = 1'b0;
    wait_mode(ST_NORMAL_REQ, 8);
    chk(8'(irq_n), 8'h1);
    go_normal();
  endtask : t_reset_pin
  task automatic t_watchdog();
    cmd(2'h0);
    chk(8'(mode), 8'(ST_NORMAL));
    chk(8'(wd_run), 8'h1);
    wd_open = 1'b0;
    cmd(2'h0);
    wd_open = 1'b1;
    chk(8'(mode), 8'(ST_RESET));
    go_normal();
    pulse(wd_exp);
    chk(8'(mode), 8'(ST_RESET));
    go_normal();
    gnd = 1'b1;
    pulse(wd_exp);
    chk(8'(mode), 8'(ST_NORMAL));
    chk(8'(wd_run), 8'h0);
    pulse(reg_low);
    chk(8'(mode), 8'(ST_RESET));
    wait_mode(ST_NORMAL, RST_EXT + 10);
    gnd = 1'b0;
  endtask : t_watchdog
  task automatic t_faults();
    for (int i = 0; i < 6; i++) begin
      mask = 6'h3f;
      flt[i] = 1'b1;
      tick(3);
      chk(8'(irq_n), 8'h1);
      mask = 6'h0;
      tick(3);
      chk(8'(irq_n), 8'h0);
      flt[i] = 1'b0;
      pulse(ack_en);
      chk(8'(irq_n), 8'h1);
      chk(8'(lin_tx), 8'(i < 3));
    end
    txd_rec = 1'b1;
    tick(3);
    chk(8'(lin_tx), 8'h1);
    reg_ot = 1'b1;
    tick(3);
    chk({ot_flag, reg_on}, 8'h2);
  endtask : t_faults

  task automatic test_done();
    $display("errors %0d in %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    tick(2);
    resetn_i = 1'b1;
    t_power_up();
    t_stop_cs_timeout();
    t_stop_wakes();
    t_sleep();
    t_reset_pin();
    t_watchdog();
    t_faults();
    test_done();
  end
  // The scenarios need about four hundred cycles; this is some fifteen times that
  initial begin
    #60000;
    n_errors++;
    test_done();
  end
endmodule : mode_reset_wake_controller_bench
